//--- logic/hbg_pkg.sv
/*
 * Constants and types shared by the H-bridge gate control and fault logic.
 * Assumes a 10 MHz clk_i, and analog comparators that are already
 * synchronous to it.
 */
// How it works
// - Enable low: outputs off, sleep, flag high
// - Enable high: awake, inputs steer outputs
// - Undriven enable reads low, device sleeps
// - Healthy and enabled: outputs follow polarity inputs
// - First disable high: outputs off, flag low
// - Undervoltage: outputs off, flag low, auto-recover
// - Short or overtemp latches outputs off, flag low
// - Disable fall or enable rise clears short latch
// - Supply power-up clears every latched fault
// - Current limit: outputs off for fixed off-time
// - Above foldback temperature use reduced limit threshold
// - Above shutdown temperature latch overtemperature fault
// - Overtemp clear needs temperature below threshold
// - Fault flag active low, open drain
// - Blanking restarts on output change, masks limit
`default_nettype none
package hbg_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned OFF_TIME_US = 20;
    localparam int unsigned BLANK_NS = 2_000;
    localparam int unsigned OFF_CYC = OFF_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned BLANK_CYC = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
    localparam int unsigned CNT_W = 12;
    localparam logic [CNT_W-1:0] OFF_TC = CNT_W'(OFF_CYC - 1);
    localparam logic [CNT_W-1:0] BLANK_TC = CNT_W'(BLANK_CYC - 1);

    typedef enum logic [1:0] {
        HBG_SLEEP = 2'b00,
        HBG_RUN = 2'b01,
        HBG_OFF = 2'b10,
        HBG_LATCH = 2'b11
    } hbg_state_t;
endpackage : hbg_pkg
`default_nettype wire

//--- logic/hbg_timer.sv
/*
 * One-shot down counter: a start pulse loads a terminal count, busy
 * stays high until it runs out. Assumes one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module hbg_timer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Control
    input wire logic start_i,
    input wire logic [hbg_pkg::CNT_W-1:0] tc_i,
    // Status
    output logic busy_o
);
    logic [hbg_pkg::CNT_W-1:0] cnt_ff;
    logic [hbg_pkg::CNT_W-1:0] nxt_cnt;
    logic busy_ff;
    logic nxt_busy;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_busy = busy_ff;
        if (start_i) begin
            nxt_cnt = tc_i;
            nxt_busy = 1'b1;
        end else if (busy_ff) begin
            if (cnt_ff == '0) begin
                nxt_busy = 1'b0;
            end else begin
                nxt_cnt = cnt_ff - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
        end
    end

    assign busy_o = busy_ff;
endmodule : hbg_timer
`default_nettype wire

//--- logic/hbg_core.sv
/*
 * Gate control and protection logic of an H-bridge: drive decode, sleep,
 * constant off-time current limiting with blanking, fault latches.
 * Assumes all inputs synchronous to clk_i; nrst_i is the power-on reset
 * of the main supply. Undriven pins are resolved here from their oe inputs: enable reads low, disable reads high.
 */
`timescale 1ns/1ps
`default_nettype none
module hbg_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Control pins
    input wire logic enable_sleep_input_i,
    input wire logic enable_sleep_input_oe_i,
    input wire logic disable_input_first_i,
    input wire logic disable_input_first_oe_i,
    input wire logic polarity_input_a_i,
    input wire logic polarity_input_b_i,
    // Analog comparators
    input wire logic undervoltage_i,
    input wire logic short_circuit_i,
    input wire logic over_limit_normal_i,
    input wire logic over_limit_reduced_i,
    input wire logic temp_foldback_i,
    input wire logic temp_shutdown_i,
    input wire logic temp_below_hyst_i,
    // Bridge gate drive
    output logic bridge_output_a_o,
    output logic bridge_output_a_oe_o,
    output logic bridge_output_b_o,
    output logic bridge_output_b_oe_o,
    // Fault flag, open drain
    output logic fault_flag_n_o,
    output logic fault_flag_n_oe_o,
    // Status
    output logic sleep_o,
    output logic limit_active_o
);
    logic en_ff;
    logic dis_ff;
    logic sc_latch_ff;
    logic ot_latch_ff;
    logic nxt_sc_latch;
    logic nxt_ot_latch;
    logic out_a_ff;
    logic out_b_ff;
    logic oe_ff;
    logic flag_oe_ff;
    logic sleep_ff;
    logic nxt_out_a;
    logic nxt_out_b;
    logic nxt_oe;
    logic nxt_flag_oe;
    logic en_lvl;
    logic dis_lvl;
    logic en_rise;
    logic dis_fall;
    logic limit_hit;
    logic threshold;
    logic off_busy;
    logic blank_busy;
    logic drive_ok;
    logic out_change;
    logic off_start;

    assign en_lvl = enable_sleep_input_oe_i & enable_sleep_input_i;
    assign dis_lvl = ~disable_input_first_oe_i | disable_input_first_i;

    // Sampled edges, one clear per edge
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_ff <= 1'b0;
            dis_ff <= 1'b1;
        end else begin
            en_ff <= en_lvl;
            dis_ff <= dis_lvl;
        end
    end
    assign en_rise = en_lvl & ~en_ff;
    assign dis_fall = ~dis_lvl & dis_ff;

    assign threshold = temp_foldback_i ? over_limit_reduced_i : over_limit_normal_i;
    assign limit_hit = threshold & ~blank_busy & oe_ff;

    // Fault latches; a new detection wins over a clear in the same cycle
    always_comb begin
        nxt_sc_latch = sc_latch_ff;
        nxt_ot_latch = ot_latch_ff;
        if (en_rise || dis_fall) begin
            nxt_sc_latch = 1'b0;
        end
        if ((en_rise && !temp_shutdown_i) || (dis_fall && temp_below_hyst_i)) begin
            nxt_ot_latch = 1'b0;
        end
        if (short_circuit_i && oe_ff) begin
            nxt_sc_latch = 1'b1;
        end
        if (temp_shutdown_i && en_lvl) begin
            nxt_ot_latch = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sc_latch_ff <= 1'b0;
            ot_latch_ff <= 1'b0;
        end else begin
            sc_latch_ff <= nxt_sc_latch;
            ot_latch_ff <= nxt_ot_latch;
        end
    end

    assign drive_ok = en_lvl & ~dis_lvl & ~undervoltage_i & ~nxt_sc_latch & ~nxt_ot_latch;
    assign off_start = limit_hit & ~off_busy;

    hbg_timer u_off_timer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .start_i(off_start),
        .tc_i(hbg_pkg::OFF_TC),
        .busy_o(off_busy)
    );

    assign out_change = (nxt_oe != oe_ff) || (nxt_oe && ((nxt_out_a != out_a_ff) ||
                        (nxt_out_b != out_b_ff)));

    hbg_timer u_blank_timer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .start_i(out_change),
        .tc_i(hbg_pkg::BLANK_TC),
        .busy_o(blank_busy)
    );

    always_comb begin
        nxt_out_a = polarity_input_a_i;
        nxt_out_b = polarity_input_b_i;
        nxt_oe = drive_ok & ~off_busy & ~off_start;
        // Flag low on fault, high asleep
        nxt_flag_oe = en_lvl & (dis_lvl | undervoltage_i | nxt_sc_latch | nxt_ot_latch);
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_a_ff <= 1'b0;
            out_b_ff <= 1'b0;
            oe_ff <= 1'b0;
            flag_oe_ff <= 1'b0;
            sleep_ff <= 1'b1;
        end else begin
            out_a_ff <= nxt_out_a;
            out_b_ff <= nxt_out_b;
            oe_ff <= nxt_oe;
            flag_oe_ff <= nxt_flag_oe;
            sleep_ff <= ~en_lvl;
        end
    end

    assign bridge_output_a_o = out_a_ff;
    assign bridge_output_b_o = out_b_ff;
    assign bridge_output_a_oe_o = oe_ff;
    assign bridge_output_b_oe_o = oe_ff;
    // Open drain, only ever pulls low
    assign fault_flag_n_o = 1'b0;
    assign fault_flag_n_oe_o = flag_oe_ff;
    assign sleep_o = sleep_ff;
    assign limit_active_o = off_busy;

    sequence s_limit_trip;
        limit_hit && !off_busy;
    endsequence

    // Sleep: outputs off, flag released
    AST_SLEEP_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !en_lvl |=> !oe_ff && !flag_oe_ff) else $error("sleep did not release bridge");
    AST_DISABLE_FLAG: assert property (@(posedge clk_i) disable iff (!nrst_i)
        en_lvl && dis_lvl |=> !oe_ff && flag_oe_ff) else $error("disable not honoured");
    AST_FOLLOW: assert property (@(posedge clk_i) disable iff (!nrst_i)
        oe_ff |-> out_a_ff == $past(polarity_input_a_i) && out_b_ff == $past(polarity_input_b_i))
        else $error("outputs not following inputs");
    AST_UV: assert property (@(posedge clk_i) disable iff (!nrst_i)
        en_lvl && undervoltage_i |=> !oe_ff && flag_oe_ff) else $error("undervoltage missed");
    AST_SC_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
        sc_latch_ff && !en_rise && !dis_fall |=> sc_latch_ff) else $error("short latch leaked");
    AST_SC_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
        sc_latch_ff && dis_fall && !(short_circuit_i && oe_ff) |=> !sc_latch_ff)
        else $error("short latch not cleared");
    AST_OT_QUAL: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ot_latch_ff && dis_fall && !en_rise && !temp_below_hyst_i |=> ot_latch_ff)
        else $error("overtemp cleared while hot");
    AST_OT_SET: assert property (@(posedge clk_i) disable iff (!nrst_i)
        temp_shutdown_i && en_lvl |=> ot_latch_ff && !oe_ff) else $error("no overtemp latch");
    AST_OFF_TIME: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_limit_trip |=> !oe_ff [*8]) else $error("off-time too short");
    AST_BLANK: assert property (@(posedge clk_i) disable iff (!nrst_i)
        blank_busy |-> !off_start) else $error("limit acted during blanking");

    // Run length of each timer window, watched by the length checks below
    logic [1:0] tmr_busy;
    assign tmr_busy = {blank_busy, off_busy};
    for (genvar gi = 0; gi < 2; gi++) begin : g_run
        logic [hbg_pkg::CNT_W-1:0] len_ff;
        logic [hbg_pkg::CNT_W-1:0] nxt_len;
        // Saturates, so a long chain of blanking restarts cannot wrap
        always_comb begin
            nxt_len = '0;
            if (tmr_busy[gi]) begin
                nxt_len = (len_ff == '1) ? len_ff : len_ff + 1'b1;
            end
        end
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                len_ff <= '0;
            end else begin
                len_ff <= nxt_len;
            end
        end
    end

    sequence s_short_en_clear;
        sc_latch_ff && en_rise && !(short_circuit_i && oe_ff);
    endsequence

    sequence s_fold_trip;
        temp_foldback_i && over_limit_reduced_i && !blank_busy && oe_ff && !off_busy;
    endsequence

    AST_SC_EN_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_short_en_clear |=> !sc_latch_ff) else $error("enable rise kept short latch");
    AST_OT_EN_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ot_latch_ff && en_rise && !temp_shutdown_i |=> !ot_latch_ff)
        else $error("enable rise kept overtemp latch");
    AST_OT_DIS_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ot_latch_ff && dis_fall && temp_below_hyst_i && !temp_shutdown_i |=> !ot_latch_ff)
        else $error("disable fall kept cool overtemp latch");
    // Latched faults keep the bridge off whatever the polarity inputs do
    AST_LATCH_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (sc_latch_ff || ot_latch_ff) |-> !oe_ff) else $error("bridge driven while latched");
    AST_LATCH_FLAG: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (sc_latch_ff || ot_latch_ff) && !sleep_ff |-> flag_oe_ff)
        else $error("latched fault not flagged");
    AST_SLEEP_FLAG: assert property (@(posedge clk_i) disable iff (!nrst_i)
        sleep_ff |-> !flag_oe_ff && !oe_ff) else $error("flag or bridge active asleep");
    AST_BLANK_START: assert property (@(posedge clk_i) disable iff (!nrst_i)
        out_change |=> blank_busy) else $error("blanking not restarted");
    AST_FOLD_TRIP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_fold_trip |=> !oe_ff && off_busy) else $error("reduced threshold ignored");
    AST_NO_FOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !temp_foldback_i && !over_limit_normal_i |-> !off_start)
        else $error("reduced threshold used while cool");
    // Whole off-time, counted at the cycle the window closes
    AST_OFF_LEN: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $fell(off_busy) |-> g_run[0].len_ff == hbg_pkg::OFF_TC + 1'b1)
        else $error("off-time length wrong");
    AST_BLANK_LEN: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $fell(blank_busy) |-> g_run[1].len_ff >= hbg_pkg::BLANK_TC + 1'b1)
        else $error("blanking window too short");
endmodule : hbg_core
`default_nettype wire

//--- tb/hbg_host.sv
/*
 * Host controller pads: passes commands to the control pins and
 * resolves the open-drain fault flag. Assumes tb drives the commands.
 */
`timescale 1ns/1ps
`default_nettype none
module hbg_host (
    // Clock
    input wire logic clk_i,
    // Commands
    input wire logic en_i,
    input wire logic en_oe_i,
    input wire logic dis_i,
    input wire logic dis_oe_i,
    // Device flag
    input wire logic flag_n_i,
    input wire logic flag_n_oe_i,
    // Pins
    output logic en_pin_o,
    output logic dis_pin_o,
    output logic flag_level_o
);
    logic toggle_ff = 1'b0;

    // Released pins wander, so the device must use its own default
    always @(posedge clk_i) begin
        toggle_ff <= ~toggle_ff;
    end
    assign en_pin_o = en_oe_i ? en_i : toggle_ff;
    assign dis_pin_o = dis_oe_i ? dis_i : ~toggle_ff;
    assign flag_level_o = flag_n_oe_i ? flag_n_i : 1'b1;
endmodule : hbg_host
`default_nettype wire

//--- tb/tb.sv
/*
 * Self-checking bench of the H-bridge gate logic.
 * Assumes hbg_core with package counts: 20 cycle blanking, 200 off.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int LIMIT = 3000;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [5:0] pins = 6'b001000;
    logic [6:0] cmp = 7'h01;
    logic en_pin, dis_pin, flag_lvl, flag_n, flag_oe, sleep, limit;
    logic out_a, oe_a, out_b, oe_b;
    wire logic [7:0] obs;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;

    assign obs = {1'b0, sleep, limit, oe_a, oe_b, out_a & oe_a, out_b & oe_b, flag_lvl};
    always #50 clk_i = ~clk_i;

    hbg_host host (.clk_i(clk_i), .en_i(pins[4]), .en_oe_i(pins[5]), .dis_i(pins[2]),
        .dis_oe_i(pins[3]), .flag_n_i(flag_n), .flag_n_oe_i(flag_oe),
        .en_pin_o(en_pin), .dis_pin_o(dis_pin), .flag_level_o(flag_lvl));

    hbg_core dut (.clk_i(clk_i), .nrst_i(nrst_i), .enable_sleep_input_i(en_pin),
        .enable_sleep_input_oe_i(pins[5]), .disable_input_first_i(dis_pin),
        .disable_input_first_oe_i(pins[3]), .polarity_input_a_i(pins[1]),
        .polarity_input_b_i(pins[0]), .undervoltage_i(cmp[6]), .short_circuit_i(cmp[5]),
        .over_limit_normal_i(cmp[4]), .over_limit_reduced_i(cmp[3]),
        .temp_foldback_i(cmp[2]), .temp_shutdown_i(cmp[1]), .temp_below_hyst_i(cmp[0]),
        .bridge_output_a_o(out_a), .bridge_output_a_oe_o(oe_a),
        .bridge_output_b_o(out_b), .bridge_output_b_oe_o(oe_b),
        .fault_flag_n_o(flag_n), .fault_flag_n_oe_o(flag_oe),
        .sleep_o(sleep), .limit_active_o(limit));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Pins: en_oe, en, dis_oe, dis, a, b
    task automatic drive(input logic [5:0] p);
        @(posedge clk_i);
        pins <= p;
        tick(3);
    endtask : drive

    // Comparators: uv, short, lim, lim_red, foldback, shutdown, below_hyst
    task automatic set_cmp(input logic [6:0] v);
        @(posedge clk_i);
        cmp <= v;
        tick(3);
    endtask : set_cmp

    task automatic pulse_cmp(input logic [6:0] v, input logic [6:0] after);
        @(posedge clk_i);
        cmp <= v;
        @(posedge clk_i);
        cmp <= after;
    endtask : pulse_cmp

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        tick(2);
        check(obs, 8'h41);
        for (int i = 0; i < 4; i++) begin
            drive({4'b1110, i[1:0]});
            check(obs, {3'b000, 2'b11, i[1], i[0], 1'b1});
        end
        drive(6'b111110);
        check(obs, 8'h00);
        drive(6'b110010);
        check(obs, 8'h00);
        drive(6'b011010);
        check(obs, 8'h41);
        drive(6'b101010);
        check(obs, 8'h41);
        drive(6'b111010);
        set_cmp(7'h41);
        check(obs, 8'h00);
        set_cmp(7'h01);
        check(obs, 8'h1D);
        set_cmp(7'h21);
        set_cmp(7'h01);
        drive(6'b111001);
        check(obs, 8'h00);
        drive(6'b111101);
        drive(6'b111001);
        check(obs, 8'h1B);
        set_cmp(7'h21);
        set_cmp(7'h01);
        drive(6'b101001);
        drive(6'b111001);
        check(obs, 8'h1B);
        set_cmp(7'h21);
        set_cmp(7'h01);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        tick(2);
        check(obs, 8'h41);
        @(posedge clk_i);
        nrst_i <= 1'b1;
        tick(3);
        check(obs, 8'h1B);
        set_cmp(7'h02);
        check(obs, 8'h00);
        set_cmp(7'h00);
        drive(6'b111101);
        drive(6'b111001);
        check(obs, 8'h00);
        drive(6'b101001);
        drive(6'b111001);
        check(obs, 8'h1B);
        set_cmp(7'h02);
        drive(6'b101001);
        drive(6'b111001);
        check(obs, 8'h00);
        set_cmp(7'h01);
        drive(6'b111101);
        drive(6'b111001);
        check(obs, 8'h1B);
        tick(25);
        pulse_cmp(7'h11, 7'h01);
        tick(100);
        check(obs, 8'h21);
        // First cycle after the off-time: limit clear, outputs still off, then drive resumes
        tick(100);
        check(obs, 8'h01);
        tick(1);
        check(obs, 8'h1B);
        // Let the earlier blanking lapse, so only a restart can mask
        tick(20);
        drive(6'b111010);
        pulse_cmp(7'h11, 7'h01);
        tick(3);
        check(obs, 8'h1D);
        tick(25);
        set_cmp(7'h09);
        check(obs, 8'h1D);
        set_cmp(7'h01);
        pulse_cmp(7'h0D, 7'h05);
        tick(3);
        check(obs, 8'h21);
        set_cmp(7'h01);
        tick(205);
        check(obs, 8'h1D);
        conclude();
    end
endmodule : tb
`default_nettype wire
